//--- testbench/sampling_clock_synth_and_clock_outputs_tb.sv
`timescale 1ns/1ps
module sampling_clock_synth_and_clock_outputs_tb import scs_pkg::*;;
  localparam logic [7:0] REF_EDGES = 8'h1e;
  localparam logic [7:0] SE_EDGES = 8'h14;
  localparam logic [7:0] LINE_EDGES = 8'h14;
  logic clk, reset_n, reg_wr_en, reg_rd_en, synth_on, ref_sel, pd, ts, ovr_c, ovr_d;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wr_data, reg_rd_data, d;
  logic [1:0] cfg, noise_suppress_on;
  logic diff_ref, se_ref, line_clk;
  logic sample_clock_from_synth, synth_ref_from_single_ended, synth_in_reset, synth_locked;
  logic [7:0] vco_divisor_product, feedback_divider, e_v, s_v;
  logic refrep, trig, aux1, aux2, pr_v, cnt_clr;
  logic rd_seen = 1'b0;
  logic [3:0] prv = 4'h0;
  logic [7:0] exp_q[$];
  logic [7:0] fb_tab[5] = '{8'h32, 8'h42, 8'h52, 8'h34, 8'h44};
  int pr_sel;
  int cyc = 0;
  int fail_count = 0;
  int checks = 0;
  int cnt[4] = '{default: 0};

  scs_ref_source src (.clk(clk), .diff_ref(diff_ref), .se_ref(se_ref), .line_clk(line_clk));

  scs_clock_ctrl #(.RATIO_W(8), .QUAD_PART(1'b1)) dut (
    .clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .converter_synth_on_pin(synth_on), .single_ended_ref_select(ref_sel),
    .powerdown_pin(pd), .cmos_clock_config_pins(cfg), .diff_clock_input(diff_ref),
    .single_ended_ref_input(se_ref), .timestamp_input(ts), .serializer_line_clock(line_clk),
    .overrange_c(ovr_c), .overrange_d(ovr_d),
    .sample_clock_from_synth(sample_clock_from_synth),
    .synth_ref_from_single_ended(synth_ref_from_single_ended),
    .synth_in_reset(synth_in_reset), .vco_divisor_product(vco_divisor_product),
    .feedback_divider(feedback_divider), .noise_suppress_on(noise_suppress_on),
    .synth_locked(synth_locked), .reference_repeat_output(refrep),
    .trigger_clock_output(trig), .cmos_aux_output_one(aux1), .cmos_aux_output_two(aux2)
  );

  always #25 clk = ~clk;

  task automatic final_report;
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  function automatic logic [7:0] obs(input int sel);
    case (sel)
      1: return {4'h0, synth_locked, synth_ref_from_single_ended, sample_clock_from_synth,
                 synth_in_reset};
      2: return vco_divisor_product;
      3: return feedback_divider;
      4: return {6'h00, noise_suppress_on};
      5, 6, 7, 8: return 8'(cnt[sel-5]);
      default: return {6'h00, aux2, aux1};
    endcase
  endfunction : obs

  // Rising edges are counted per output, so clock rates are judged with one edge of slack.
  wire [3:0] outs_now = {aux2, aux1, trig, refrep};
  always @(posedge clk) begin
    prv <= outs_now;
    for (int k = 0; k < 4; k++) begin
      if (cnt_clr) cnt[k] <= 0;
      else if (outs_now[k] && !prv[k]) cnt[k] <= cnt[k] + 1;
    end
  end

  always @(posedge clk) begin
    rd_seen <= reg_rd_en;
    if (rd_seen) check(reg_rd_data, exp_q.pop_front());
    if (pr_v) begin
      e_v = exp_q.pop_front();
      s_v = obs(pr_sel);
      // A silent output must show no edge at all; only running clocks get the slack.
      if (pr_sel inside {[5:8]} && e_v != 8'h00 && s_v + 8'h01 >= e_v && s_v <= e_v + 8'h01)
        s_v = e_v;
      check(s_v, e_v);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= v;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
  endtask : rd

  task automatic probe(input int sel, input logic [7:0] v);
    exp_q.push_back(v);
    @(posedge clk);
    pr_v <= 1'b1;
    pr_sel <= sel;
    @(posedge clk);
    pr_v <= 1'b0;
  endtask : probe

  task automatic clr_wait;
    repeat (8) @(posedge clk);
    cnt_clr <= 1'b1;
    @(posedge clk);
    cnt_clr <= 1'b0;
  endtask : clr_wait

  task automatic window;
    clr_wait();
    repeat (240) @(posedge clk);
  endtask : window

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = '0;
    reg_wr_data = '0;
    synth_on = 1'b0;
    ref_sel = 1'b0;
    pd = 1'b0;
    cfg = 2'h0;
    ts = 1'b0;
    ovr_c = 1'b0;
    ovr_d = 1'b0;
    pr_v = 1'b0;
    pr_sel = 0;
    cnt_clr = 1'b0;
    void'($urandom(19));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    probe(1, 8'h01);
    rd(ADDR_HOLD, HOLD_RST);
    rd(ADDR_REF_REPEAT, REF_REPEAT_RST);
    rd(ADDR_TRIG_CTRL, TRIG_CTRL_RST);
    rd(12'h100, 8'h00);
    wr(ADDR_CAL_STAT, 8'hff);
    rd(ADDR_CAL_STAT, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(ADDR_NOISE, d);
      rd(ADDR_NOISE, d);
      probe(4, {6'h00, d[1:0]});
      d = 8'($urandom);
      wr(ADDR_FBDIV_TWO, d);
      rd(ADDR_FBDIV_TWO, d);
      probe(3, d);
    end
    // Only the supported divisor products are ever programmed.
    foreach (fb_tab[i]) begin
      wr(ADDR_FBDIV_ONE, fb_tab[i]);
      rd(ADDR_FBDIV_ONE, fb_tab[i]);
      probe(2, {4'h0, fb_tab[i][7:4]} * {4'h0, fb_tab[i][3:0]});
    end
    window();
    probe(5, 8'h00);
    probe(6, 8'h00);
    synth_on <= 1'b1;
    ref_sel <= 1'b1;
    window();
    probe(1, 8'h07);
    probe(5, SE_EDGES);
    ref_sel <= 1'b0;
    window();
    probe(5, REF_EDGES);
    wr(ADDR_REF_REPEAT, 8'h00);
    window();
    probe(5, 8'h00);
    wr(ADDR_REF_REPEAT, 8'h01);
    cfg <= 2'h3;
    pd <= 1'b1;
    window();
    probe(5, 8'h00);
    probe(7, 8'h00);
    probe(8, 8'h00);
    pd <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      cfg <= 2'(c);
      window();
      probe(7, c == 0 ? 8'h00 : REF_EDGES >> (c - 1));
      probe(8, c == 0 ? 8'h00 : REF_EDGES);
    end
    cfg <= 2'h0;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_AUX_CTRL, 8'h14 | 8'(m));
      window();
      probe(7, m == 0 ? 8'h00 : REF_EDGES >> (m - 1));
      probe(8, m == 0 ? 8'h00 : REF_EDGES);
    end
    ovr_c <= 1'b1;
    ovr_d <= 1'b1;
    wr(ADDR_AUX_CTRL, 8'h30);
    repeat (8) @(posedge clk);
    probe(9, 8'h03);
    wr(ADDR_AUX_CTRL, 8'h35);
    window();
    probe(7, REF_EDGES);
    probe(8, REF_EDGES);
    ovr_c <= 1'b0;
    ovr_d <= 1'b0;
    wr(ADDR_LINE_DIV, 8'h02);
    wr(ADDR_TRIG_CTRL, 8'h01);
    window();
    probe(6, LINE_EDGES);
    wr(ADDR_TRIG_CTRL, 8'h07);
    clr_wait();
    repeat (5) begin
      ts <= 1'b1;
      repeat (4) @(posedge clk);
      ts <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    probe(6, 8'h05);
    // The synthesizer is held in reset while it is reprogrammed.
    wr(ADDR_HOLD, 8'h01);
    wr(ADDR_FBDIV_ONE, 8'h32);
    wr(ADDR_FBDIV_TWO, 8'h0a);
    wr(ADDR_CAL_CTRL, 8'h01);
    wr(ADDR_HOLD, 8'h00);
    repeat (CAL_CYC - 20) @(posedge clk);
    rd(ADDR_CAL_STAT, 8'h00);
    repeat (40) @(posedge clk);
    rd(ADDR_CAL_STAT, 8'h01);
    rd(ADDR_LINK_STAT, 8'h00);
    probe(1, 8'h02);
    repeat (LOCK_CYC) @(posedge clk);
    rd(ADDR_LINK_STAT, 8'h01);
    probe(1, 8'h0a);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : sampling_clock_synth_and_clock_outputs_tb

//--- testbench/scs_ref_source.sv
`timescale 1ns/1ps
// Board reference source and serializer line clock, slow models locked to the bench clock.
// The two references run at different rates so that the selected one can be told apart.
module scs_ref_source #(
  parameter int DIFF_HALF = 4,
  parameter int SE_HALF = 6,
  parameter int LINE_HALF = 3
) (
  input wire logic clk,
  output logic diff_ref,
  output logic se_ref,
  output logic line_clk
);
  int diff_cnt = 0;
  int se_cnt = 0;
  int line_cnt = 0;
  logic diff_q = 1'b0;
  logic se_q = 1'b0;
  logic line_q = 1'b0;

  assign diff_ref = diff_q;
  assign se_ref = se_q;
  assign line_clk = line_q;

  // The differential input runs free, so it also serves as the direct sampling clock.
  always @(posedge clk) begin
    diff_cnt <= (diff_cnt == DIFF_HALF - 1) ? 0 : diff_cnt + 1;
    if (diff_cnt == DIFF_HALF - 1) diff_q <= ~diff_q;
    se_cnt <= (se_cnt == SE_HALF - 1) ? 0 : se_cnt + 1;
    if (se_cnt == SE_HALF - 1) se_q <= ~se_q;
    line_cnt <= (line_cnt == LINE_HALF - 1) ? 0 : line_cnt + 1;
    if (line_cnt == LINE_HALF - 1) line_q <= ~line_q;
  end
endmodule : scs_ref_source

//--- verilog/scs_clk_div.sv
`timescale 1ns/1ps
module scs_clk_div #(
  parameter int RATIO_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  scs_div_if.div dv
);
  logic src_prev_q;
  logic out_q;
  logic [RATIO_W-1:0] edge_cnt_q;
  logic [RATIO_W-1:0] ratio_eff;

  generate
    if (RATIO_W < 2) begin : g_bad_width
      $error("scs_clk_div needs RATIO_W of at least 2");
    end
  endgenerate

  // A ratio of zero is served as one so the output never freezes high.
  assign ratio_eff = (dv.ratio == '0) ? RATIO_W'(1) : dv.ratio;

  // Counting both input edges lets odd ratios keep a whole output period.
  always_ff @(posedge clk) begin
    if (!reset_n || !dv.enable) begin
      src_prev_q <= 1'b0;
      edge_cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      src_prev_q <= dv.src;
      if (dv.src != src_prev_q) begin
        if (edge_cnt_q >= ratio_eff - RATIO_W'(1)) begin
          edge_cnt_q <= '0;
          out_q <= ~out_q;
        end else begin
          edge_cnt_q <= edge_cnt_q + RATIO_W'(1);
        end
      end
    end
  end

  assign dv.out = out_q;
endmodule : scs_clk_div

//--- verilog/scs_clock_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Synthesizer runs only with enable pin high.
// - Reference select pin picks differential or single-ended.
// - Sample rate is VCO over V times P.
// - Dividers held in two consecutive registers.
// - Armed calibration runs when hold reset clears.
// - Lock needs calibration done and lock flag.
// - Noise suppression bits for two supplies.
// - Reference repeat on by default, software disable.
// - Reference repeat needs synthesizer on, powerdown low.
// - Trigger output off until enabled, two sources.
// - Serializer source divided by line clock divider.
// - Aux clocks from pins, stopped while powerdown high.
// - Register mode fields override the config pins.
// - Pins divide aux one, only enable aux two.
// - Clock function beats over-range on aux pins.
// - Aux two clock needs aux one mode nonzero.
// - Pin codes: off/over-range, divide 1, 2, 4.
// - Override modes decode the same way.
module scs_clock_ctrl import scs_pkg::*; #(
  parameter int RATIO_W = 8,
  parameter bit QUAD_PART = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wr_data,
  output logic [DATA_W-1:0] reg_rd_data,
  input wire logic converter_synth_on_pin,
  input wire logic single_ended_ref_select,
  input wire logic powerdown_pin,
  input wire logic [1:0] cmos_clock_config_pins,
  input wire logic diff_clock_input,
  input wire logic single_ended_ref_input,
  input wire logic timestamp_input,
  input wire logic serializer_line_clock,
  input wire logic overrange_c,
  input wire logic overrange_d,
  output logic sample_clock_from_synth,
  output logic synth_ref_from_single_ended,
  output logic synth_in_reset,
  output logic [7:0] vco_divisor_product,
  output logic [7:0] feedback_divider,
  output logic [1:0] noise_suppress_on,
  output logic synth_locked,
  output logic reference_repeat_output,
  output logic trigger_clock_output,
  output logic cmos_aux_output_one,
  output logic cmos_aux_output_two
);
  localparam int PIN_N = 9;

  generate
    if (RATIO_W != DATA_W) begin : g_bad_ratio
      $error("scs_clock_ctrl needs RATIO_W equal to the register width");
    end
  endgenerate

  // Mode code to ratio: 0 means no clock, then divide by 1, 2 and 4.
  function automatic logic [RATIO_W-1:0] mode_ratio(input logic [1:0] mode);
    case (mode)
      2'h1: mode_ratio = RATIO_W'(1);
      2'h2: mode_ratio = RATIO_W'(2);
      2'h3: mode_ratio = RATIO_W'(4);
      default: mode_ratio = '0;
    endcase
  endfunction : mode_ratio

  // Pins are asynchronous to clk; nothing reads the first stage but the second.
  logic [PIN_N-1:0] pin_meta_q;
  logic [PIN_N-1:0] pin_sync_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {serializer_line_clock, timestamp_input, single_ended_ref_input,
                     diff_clock_input, cmos_clock_config_pins, powerdown_pin,
                     single_ended_ref_select, converter_synth_on_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic synth_on_s;
  logic ref_se_s;
  logic pd_s;
  logic [1:0] cfg_s;
  logic diff_s;
  logic se_s;
  logic tstamp_s;
  logic line_s;
  assign synth_on_s = pin_sync_q[0];
  assign ref_se_s = pin_sync_q[1];
  assign pd_s = pin_sync_q[2];
  assign cfg_s = pin_sync_q[4:3];
  assign diff_s = pin_sync_q[5];
  assign se_s = pin_sync_q[6];
  assign tstamp_s = pin_sync_q[7];
  assign line_s = pin_sync_q[8];

  logic [7:0] noise_q;
  logic [7:0] trig_ctrl_q;
  logic [7:0] line_div_q;
  logic [7:0] ref_repeat_q;
  logic [7:0] aux_ctrl_q;
  logic [7:0] fbdiv_one_q;
  logic [7:0] fbdiv_two_q;
  logic [7:0] hold_q;
  logic [7:0] cal_ctrl_q;
  logic cal_done_q;
  logic lock_flag_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      noise_q <= NOISE_RST;
      trig_ctrl_q <= TRIG_CTRL_RST;
      line_div_q <= LINE_DIV_RST;
      ref_repeat_q <= REF_REPEAT_RST;
      aux_ctrl_q <= AUX_CTRL_RST;
      fbdiv_one_q <= FBDIV_ONE_RST;
      fbdiv_two_q <= FBDIV_TWO_RST;
      hold_q <= HOLD_RST;
      cal_ctrl_q <= CAL_CTRL_RST;
    end else if (reg_wr_en) begin
      case (reg_addr)
        ADDR_NOISE: noise_q <= reg_wr_data;
        ADDR_TRIG_CTRL: trig_ctrl_q <= reg_wr_data;
        ADDR_LINE_DIV: line_div_q <= reg_wr_data;
        ADDR_REF_REPEAT: ref_repeat_q <= reg_wr_data;
        ADDR_AUX_CTRL: aux_ctrl_q <= reg_wr_data;
        ADDR_FBDIV_ONE: fbdiv_one_q <= reg_wr_data;
        ADDR_FBDIV_TWO: fbdiv_two_q <= reg_wr_data;
        ADDR_HOLD: hold_q <= reg_wr_data;
        ADDR_CAL_CTRL: cal_ctrl_q <= reg_wr_data;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read as zero.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rd_data <= '0;
    end else if (reg_rd_en) begin
      case (reg_addr)
        ADDR_NOISE: reg_rd_data <= noise_q;
        ADDR_TRIG_CTRL: reg_rd_data <= trig_ctrl_q;
        ADDR_LINE_DIV: reg_rd_data <= line_div_q;
        ADDR_REF_REPEAT: reg_rd_data <= ref_repeat_q;
        ADDR_AUX_CTRL: reg_rd_data <= aux_ctrl_q;
        ADDR_FBDIV_ONE: reg_rd_data <= fbdiv_one_q;
        ADDR_FBDIV_TWO: reg_rd_data <= fbdiv_two_q;
        ADDR_HOLD: reg_rd_data <= hold_q;
        ADDR_CAL_CTRL: reg_rd_data <= cal_ctrl_q;
        ADDR_CAL_STAT: reg_rd_data <= {7'h00, cal_done_q};
        ADDR_LINK_STAT: reg_rd_data <= {7'h00, lock_flag_q};
        default: reg_rd_data <= '0;
      endcase
    end
  end

  // Calibration sequence; the held synthesizer forgets any earlier result.
  scs_cal_e cal_state_q;
  logic [11:0] cal_cnt_q;
  logic hold_prev_q;
  logic synth_run;
  assign synth_run = synth_on_s && !hold_q[0] && !pd_s;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cal_state_q <= SCS_CAL_IDLE;
      cal_cnt_q <= '0;
      hold_prev_q <= 1'b1;
      cal_done_q <= 1'b0;
      lock_flag_q <= 1'b0;
    end else begin
      hold_prev_q <= hold_q[0];
      if (!synth_run) begin
        cal_state_q <= SCS_CAL_IDLE;
        cal_cnt_q <= '0;
        cal_done_q <= 1'b0;
        lock_flag_q <= 1'b0;
      end else begin
        case (cal_state_q)
          SCS_CAL_IDLE: begin
            if (hold_prev_q && cal_ctrl_q[0]) begin
              cal_state_q <= SCS_CAL_RUN;
              cal_cnt_q <= 12'(CAL_CYC - 1);
            end
          end
          SCS_CAL_RUN: begin
            if (cal_cnt_q == '0) begin
              cal_state_q <= SCS_CAL_SETTLE;
              cal_done_q <= 1'b1;
              cal_cnt_q <= 12'(LOCK_CYC - 1);
            end else begin
              cal_cnt_q <= cal_cnt_q - 12'h001;
            end
          end
          SCS_CAL_SETTLE: begin
            if (cal_cnt_q == '0) begin
              cal_state_q <= SCS_CAL_LOCKED;
              lock_flag_q <= 1'b1;
            end else begin
              cal_cnt_q <= cal_cnt_q - 12'h001;
            end
          end
          SCS_CAL_LOCKED: ;
          default: cal_state_q <= SCS_CAL_IDLE;
        endcase
      end
    end
  end

  // Sampling clock path and divider settings handed to the analog macro.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sample_clock_from_synth <= 1'b0;
      synth_ref_from_single_ended <= 1'b0;
      synth_in_reset <= 1'b1;
      vco_divisor_product <= '0;
      feedback_divider <= '0;
      noise_suppress_on <= '0;
      synth_locked <= 1'b0;
    end else begin
      sample_clock_from_synth <= synth_on_s;
      synth_ref_from_single_ended <= synth_on_s && ref_se_s;
      synth_in_reset <= hold_q[0] || !synth_on_s;
      vco_divisor_product <= {4'h0, fbdiv_one_q[FB_V_LSB +: FB_FIELD_W]}
                             * {4'h0, fbdiv_one_q[FB_P_LSB +: FB_FIELD_W]};
      feedback_divider <= fbdiv_two_q;
      noise_suppress_on <= noise_q[1:0];
      synth_locked <= cal_done_q && lock_flag_q;
    end
  end

  // Reference repeat follows the selected reference input.
  logic ref_sel;
  assign ref_sel = ref_se_s ? se_s : diff_s;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reference_repeat_output <= 1'b0;
    end else begin
      reference_repeat_output <= ref_sel && ref_repeat_q[0]
                                 && synth_on_s && !pd_s;
    end
  end

  // Trigger output: retimed timestamp or divided serializer line clock.
  logic trig_ts_mode;
  assign trig_ts_mode = trig_ctrl_q[TRIG_MODE_LSB +: 2] == TRIG_MODE_TIMESTAMP;
  scs_div_if #(.RATIO_W(RATIO_W)) trig_if();
  assign trig_if.src = line_s;
  assign trig_if.enable = trig_ctrl_q[TRIG_EN_BIT] && !trig_ts_mode;
  assign trig_if.ratio = line_div_q;
  scs_clk_div #(.RATIO_W(RATIO_W)) u_trig_div (
    .clk(clk),
    .reset_n(reset_n),
    .dv(trig_if.div)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trigger_clock_output <= 1'b0;
    end else if (!trig_ctrl_q[TRIG_EN_BIT]) begin
      trigger_clock_output <= 1'b0;
    end else begin
      trigger_clock_output <= trig_ts_mode ? tstamp_s : trig_if.out;
    end
  end

  // Auxiliary CMOS outputs; pins rule unless the override bit is set.
  logic override_on;
  logic ovr_det_on;
  logic [1:0] aux_one_mode;
  logic [1:0] aux_two_mode;
  assign override_on = aux_ctrl_q[AUX_OVERRIDE_BIT];
  assign ovr_det_on = aux_ctrl_q[AUX_OVR_DET_BIT] && QUAD_PART;
  assign aux_one_mode = override_on ? aux_ctrl_q[AUX_ONE_MODE_LSB +: 2] : cfg_s;
  assign aux_two_mode = override_on ? aux_ctrl_q[AUX_TWO_MODE_LSB +: 2]
                      : ((cfg_s != 2'h0) ? 2'h1 : 2'h0);

  logic aux_one_clk_on;
  logic aux_two_clk_on;
  assign aux_one_clk_on = aux_one_mode != 2'h0;
  assign aux_two_clk_on = aux_one_clk_on && (aux_two_mode != 2'h0);

  scs_div_if #(.RATIO_W(RATIO_W)) aux_one_if();
  scs_div_if #(.RATIO_W(RATIO_W)) aux_two_if();
  assign aux_one_if.src = ref_sel;
  assign aux_one_if.enable = aux_one_clk_on && !pd_s;
  assign aux_one_if.ratio = mode_ratio(aux_one_mode);
  assign aux_two_if.src = ref_sel;
  assign aux_two_if.enable = aux_two_clk_on && !pd_s;
  assign aux_two_if.ratio = mode_ratio(aux_two_mode);
  scs_clk_div #(.RATIO_W(RATIO_W)) u_aux_one_div (
    .clk(clk),
    .reset_n(reset_n),
    .dv(aux_one_if.div)
  );
  scs_clk_div #(.RATIO_W(RATIO_W)) u_aux_two_div (
    .clk(clk),
    .reset_n(reset_n),
    .dv(aux_two_if.div)
  );

  // Over-range only reaches a pin that carries no clock.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmos_aux_output_one <= 1'b0;
      cmos_aux_output_two <= 1'b0;
    end else begin
      cmos_aux_output_one <= aux_one_clk_on ? aux_one_if.out
                             : (ovr_det_on && overrange_c);
      cmos_aux_output_two <= aux_two_clk_on ? aux_two_if.out
                             : (ovr_det_on && overrange_d);
    end
  end

  a_repeat_gated: assert property (@(posedge clk) disable iff (!reset_n)
    (!synth_on_s || pd_s || !ref_repeat_q[0]) |=> !reference_repeat_output)
    else $error("reference repeat active while gated off");

  a_repeat_follows: assert property (@(posedge clk) disable iff (!reset_n)
    (synth_on_s && !pd_s && ref_repeat_q[0]) |=> reference_repeat_output == $past(ref_sel))
    else $error("reference repeat does not follow reference");

  a_trig_off: assert property (@(posedge clk) disable iff (!reset_n)
    !trig_ctrl_q[TRIG_EN_BIT] |=> !trigger_clock_output)
    else $error("trigger output active while disabled");

  a_trig_stamp: assert property (@(posedge clk) disable iff (!reset_n)
    (trig_ctrl_q[TRIG_EN_BIT] && trig_ts_mode) |=> trigger_clock_output == $past(tstamp_s))
    else $error("trigger output does not repeat timestamp");

  a_lock_pair: assert property (@(posedge clk) disable iff (!reset_n)
    lock_flag_q |-> cal_done_q)
    else $error("lock flag without calibration complete");

  a_cal_start: assert property (@(posedge clk) disable iff (!reset_n)
    (cal_state_q == SCS_CAL_IDLE && !(synth_run && hold_prev_q && cal_ctrl_q[0]))
    |=> cal_state_q == SCS_CAL_IDLE)
    else $error("calibration left idle without an armed release");

  a_cal_runs: assert property (@(posedge clk) disable iff (!reset_n)
    (cal_state_q == SCS_CAL_IDLE && synth_run && hold_prev_q && cal_ctrl_q[0])
    |=> cal_state_q == SCS_CAL_RUN && !cal_done_q)
    else $error("armed calibration did not start on reset release");

  a_aux_two_dep: assert property (@(posedge clk) disable iff (!reset_n)
    (!aux_one_clk_on && !(ovr_det_on && overrange_d)) |=> !cmos_aux_output_two)
    else $error("aux two active without aux one clock");

  a_aux_pd: assert property (@(posedge clk) disable iff (!reset_n)
    pd_s [*2] |=> !cmos_aux_output_one || $past(!aux_one_clk_on && ovr_det_on))
    else $error("aux one clock running in powerdown");

  a_aux_prio: assert property (@(posedge clk) disable iff (!reset_n)
    aux_one_clk_on |=> cmos_aux_output_one == $past(aux_one_if.out))
    else $error("over-range reached a pin configured as clock");

  a_bypass: assert property (@(posedge clk) disable iff (!reset_n)
    !synth_on_s |=> !sample_clock_from_synth && !synth_ref_from_single_ended)
    else $error("synthesizer path selected with enable pin low");
endmodule : scs_clock_ctrl

//--- verilog/scs_div_if.sv
`timescale 1ns/1ps
interface scs_div_if #(parameter int RATIO_W = 8);
  logic src;
  logic enable;
  logic [RATIO_W-1:0] ratio;
  logic out;
  modport div(input src, input enable, input ratio, output out);
  modport user(output src, output enable, output ratio, input out);
endinterface : scs_div_if

//--- verilog/scs_pkg.sv
package scs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  localparam logic [11:0] ADDR_NOISE = 12'h02b;
  localparam logic [11:0] ADDR_TRIG_CTRL = 12'h02c;
  localparam logic [11:0] ADDR_LINE_DIV = 12'h02d;
  localparam logic [11:0] ADDR_REF_REPEAT = 12'h02e;
  localparam logic [11:0] ADDR_AUX_CTRL = 12'h02f;
  localparam logic [11:0] ADDR_FBDIV_ONE = 12'h03d;
  localparam logic [11:0] ADDR_FBDIV_TWO = 12'h03e;
  localparam logic [11:0] ADDR_HOLD = 12'h05c;
  localparam logic [11:0] ADDR_CAL_CTRL = 12'h05d;
  localparam logic [11:0] ADDR_CAL_STAT = 12'h05e;
  localparam logic [11:0] ADDR_LINK_STAT = 12'h208;

  localparam int FB_V_LSB = 0;
  localparam int FB_P_LSB = 4;
  localparam int FB_FIELD_W = 4;
  localparam int TRIG_EN_BIT = 0;
  localparam int TRIG_MODE_LSB = 1;
  localparam int AUX_ONE_MODE_LSB = 0;
  localparam int AUX_TWO_MODE_LSB = 2;
  localparam int AUX_OVERRIDE_BIT = 4;
  localparam int AUX_OVR_DET_BIT = 5;
  localparam logic [1:0] TRIG_MODE_TIMESTAMP = 2'h3;

  localparam logic [7:0] NOISE_RST = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
  localparam logic [7:0] LINE_DIV_RST = 8'h01;
  localparam logic [7:0] REF_REPEAT_RST = 8'h01;
  localparam logic [7:0] AUX_CTRL_RST = 8'h00;
  localparam logic [7:0] FBDIV_ONE_RST = 8'h00;
  localparam logic [7:0] FBDIV_TWO_RST = 8'h00;
  localparam logic [7:0] HOLD_RST = 8'h01;
  localparam logic [7:0] CAL_CTRL_RST = 8'h00;

  localparam int CLK_HZ = 20_000_000;
  localparam int CAL_TIME_NS = 100_000;
  localparam int LOCK_TIME_NS = 10_000;
  localparam int CAL_CYC = (CAL_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LOCK_CYC = (LOCK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    SCS_CAL_IDLE = 2'b00,
    SCS_CAL_RUN = 2'b01,
    SCS_CAL_SETTLE = 2'b11,
    SCS_CAL_LOCKED = 2'b10
  } scs_cal_e;
endpackage : scs_pkg
